/* rtl/rsc_pkg.sv */
// Constants, register map and timing of the reset source controller.
// Assumes a 200 MHz mclk and a 32-bit APB register port.
package rsc_pkg;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] RSC_OFS_GUARD = 8'h00;
	localparam logic [7:0] RSC_OFS_CAUSE = 8'h04;
	localparam logic [7:0] RSC_OFS_LEVEL = 8'h08;
	localparam logic [7:0] RSC_OFS_WDCTL = 8'h0C;
	localparam logic [7:0] RSC_OFS_STATUS = 8'h10;

	// ****************************************
	// reset values and codes
	// ****************************************
	localparam logic [7:0] RSC_GUARD_RST = 8'h55;
	localparam logic [7:0] RSC_GUARD_OK0 = 8'h55;
	localparam logic [7:0] RSC_GUARD_OK1 = 8'hAA;
	localparam logic [7:0] RSC_LEVEL_RST = 8'h55;
	localparam logic [7:0] RSC_LEVEL_2V10 = 8'h55;
	localparam logic [7:0] RSC_LEVEL_2V55 = 8'h33;
	localparam logic [7:0] RSC_LEVEL_3V15 = 8'h99;
	localparam logic [7:0] RSC_LEVEL_3V80 = 8'hAA;
	localparam logic [7:0] RSC_WDCTL_RST = 8'h53;
	localparam logic [4:0] RSC_WDKEY_EN = 5'h0A;
	localparam logic [4:0] RSC_WDKEY_DIS = 5'h15;
	localparam logic [3:0] RSC_CAUSE_RST = 4'h0;

	// ****************************************
	// field positions
	// ****************************************
	localparam int RSC_BIT_GUARDF = 3;
	localparam int RSC_BIT_UVF = 2;
	localparam int RSC_BIT_UVCFGF = 1;
	localparam int RSC_BIT_WDCFGF = 0;
	localparam int RSC_BIT_TIMEOUT = 0;
	localparam int RSC_BIT_PWRDOWN = 1;
	localparam int RSC_WDKEY_LSB = 3;

	// ****************************************
	// timing
	// ****************************************
	localparam int RSC_CLK_MHZ = 200;
	localparam int RSC_SOFT_RESET_DELAY_NS = 20000;
	localparam int RSC_UV_FILTER_TIME_NS = 120000;
	localparam int RSC_SOFT_RESET_CYC = (RSC_SOFT_RESET_DELAY_NS * RSC_CLK_MHZ + 999) / 1000;
	localparam int RSC_UV_FILTER_CYC = (RSC_UV_FILTER_TIME_NS * RSC_CLK_MHZ + 999) / 1000;

endpackage

/* rtl/rsc_reset_source_control.sv */
// Reset source controller: guard registers, undervolt filter, watchdog
// time-out handling, cause flags and timeout/powerdown flags.
// Assumes lowSupply comes from an analog comparator (asynchronous) and
// all other inputs except the asynchronous rst are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_source_control import rsc_pkg::*; #(
	parameter int SOFT_RESET_CYC = RSC_SOFT_RESET_CYC,
	parameter int UV_FILTER_CYC = RSC_UV_FILTER_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic lowSupply,
	input wire logic sleepMode,
	input wire logic wdtTimeout,
	input wire logic haltExec,
	input wire logic clrWdt,
	output logic fullReset,
	output logic pcSpClear,
	output logic portInit,
	output logic undervoltEnable,
	output logic [1:0] undervoltLevelSel,
	output logic wdtEnable,
	output logic [2:0] wdtPeriodSel,
	output logic timeoutFlag,
	output logic powerdownFlag
);

	// both delay counters are 20 bits wide
	if (SOFT_RESET_CYC < 1 || SOFT_RESET_CYC > 1048575) begin : gBadSoftCyc
		$error("SOFT_RESET_CYC out of range");
	end
	if (UV_FILTER_CYC < 1 || UV_FILTER_CYC > 1048575) begin : gBadUvCyc
		$error("UV_FILTER_CYC out of range");
	end

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [2:0] levelDecode(input logic [7:0] code);
		// bit 2 is valid, bits 1:0 the threshold index
		case (code)
			RSC_LEVEL_2V10: levelDecode = 3'h4;
			RSC_LEVEL_2V55: levelDecode = 3'h5;
			RSC_LEVEL_3V15: levelDecode = 3'h6;
			RSC_LEVEL_3V80: levelDecode = 3'h7;
			default: levelDecode = 3'h0;
		endcase
	endfunction

	function automatic logic isReg(input logic [7:0] addr, input logic [7:0] ofs);
		isReg = (addr == ofs);
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic [7:0] guard_q;
	logic [7:0] level_q;
	logic [7:0] wdctl_q;
	logic [3:0] cause_q;
	logic timeout_q;
	logic pwrdown_q;
	logic lowMeta_q;
	logic lowSync_q;
	logic [19:0] cfgCnt_q;
	logic [19:0] uvCnt_q;
	logic fullReset_q;
	logic pcSpClear_q;
	logic [31:0] prdata_q;

	logic wrAcc;
	logic guardBad;
	logic levelBad;
	logic keyBad;
	logic cfgBad;
	logic cfgFire;
	logic uvFire;
	logic wdtRun;
	logic wdtSleep;
	logic mapped;
	logic [4:0] wdKey;
	logic [2:0] levelInfo;

	assign wrAcc = psel & penable & pwrite;
	assign wdKey = wdctl_q[7:RSC_WDKEY_LSB];
	assign guardBad = (guard_q != RSC_GUARD_OK0) && (guard_q != RSC_GUARD_OK1);
	assign levelInfo = levelDecode(level_q);
	assign levelBad = ~levelInfo[2];
	assign keyBad = (wdKey != RSC_WDKEY_EN) && (wdKey != RSC_WDKEY_DIS);
	assign cfgBad = guardBad | levelBad | keyBad;
	assign cfgFire = cfgBad && (cfgCnt_q == 20'(SOFT_RESET_CYC - 1));
	assign undervoltEnable = ~sleepMode;
	assign uvFire = undervoltEnable && lowSync_q && (uvCnt_q == 20'(UV_FILTER_CYC));
	assign wdtRun = wdtTimeout & ~sleepMode;
	assign wdtSleep = wdtTimeout & sleepMode;

	// ****************************************
	// low supply synchroniser
	// ****************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			lowMeta_q <= 1'b0;
			lowSync_q <= 1'b0;
		end else begin
			lowMeta_q <= lowSupply;
			lowSync_q <= lowMeta_q;
		end
	end

	// ****************************************
	// delay counters
	// ****************************************
	// the request stays pending until the count completes; a valid code
	// written back before then cancels it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cfgCnt_q <= 20'h00000;
		end else if (!cfgBad || cfgFire) begin
			cfgCnt_q <= 20'h00000;
		end else begin
			cfgCnt_q <= cfgCnt_q + 20'h00001;
		end
	end

	// fires one cycle after the low level has lasted the filter time
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			uvCnt_q <= 20'h00000;
		end else if (!undervoltEnable || !lowSync_q || uvFire) begin
			uvCnt_q <= 20'h00000;
		end else begin
			uvCnt_q <= uvCnt_q + 20'h00001;
		end
	end

	// ****************************************
	// guard registers
	// ****************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			guard_q <= RSC_GUARD_RST;
		end else if (cfgFire && guardBad) begin
			guard_q <= RSC_GUARD_RST;
		end else if (wrAcc && isReg(paddr, RSC_OFS_GUARD)) begin
			guard_q <= pwdata[7:0];
		end
	end

	// a genuine undervolt reset does not touch this register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			level_q <= RSC_LEVEL_RST;
		end else if (cfgFire && levelBad) begin
			level_q <= RSC_LEVEL_RST;
		end else if (wrAcc && isReg(paddr, RSC_OFS_LEVEL)) begin
			level_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wdctl_q <= RSC_WDCTL_RST;
		end else if (cfgFire && keyBad) begin
			wdctl_q <= RSC_WDCTL_RST;
		end else if (wrAcc && isReg(paddr, RSC_OFS_WDCTL)) begin
			wdctl_q <= pwdata[7:0];
		end
	end

	// ****************************************
	// cause flags
	// ****************************************
	// writing zero clears a bit, writing one leaves it; a hardware set in
	// the same cycle wins over the clear
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cause_q <= RSC_CAUSE_RST;
		end else begin
			if (wrAcc && isReg(paddr, RSC_OFS_CAUSE)) begin
				cause_q <= cause_q & pwdata[3:0];
			end
			if (cfgFire && guardBad) begin
				cause_q[RSC_BIT_GUARDF] <= 1'b1;
			end
			if (uvFire) begin
				cause_q[RSC_BIT_UVF] <= 1'b1;
			end
			if (cfgFire && levelBad) begin
				cause_q[RSC_BIT_UVCFGF] <= 1'b1;
			end
			if (cfgFire && keyBad) begin
				cause_q[RSC_BIT_WDCFGF] <= 1'b1;
			end
		end
	end

	// ****************************************
	// timeout and powerdown flags
	// ****************************************
	// power-on clears both; undervolt reset leaves both alone
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			timeout_q <= 1'b0;
		end else if (wdtTimeout) begin
			timeout_q <= 1'b1;
		end else if (clrWdt) begin
			timeout_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pwrdown_q <= 1'b0;
		end else if (wdtSleep || haltExec) begin
			pwrdown_q <= 1'b1;
		end else if (clrWdt) begin
			pwrdown_q <= 1'b0;
		end
	end

	// ****************************************
	// reset outputs
	// ****************************************
	// high during power-on reset and its release cycle, then a one-cycle
	// pulse per full reset; the rest of the chip reinitialises on it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			fullReset_q <= 1'b1;
		end else begin
			fullReset_q <= cfgFire | uvFire | wdtRun;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pcSpClear_q <= 1'b0;
		end else begin
			pcSpClear_q <= wdtSleep;
		end
	end

	// port init only on power-on; other resets restore ports via fullReset
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			portInit <= 1'b1;
		end else begin
			portInit <= 1'b0;
		end
	end

	assign fullReset = fullReset_q;
	assign pcSpClear = pcSpClear_q;
	assign undervoltLevelSel = levelInfo[1:0];
	assign wdtEnable = (wdKey == RSC_WDKEY_EN);
	assign wdtPeriodSel = wdctl_q[2:0];
	assign timeoutFlag = timeout_q;
	assign powerdownFlag = pwrdown_q;

	// ****************************************
	// APB slave
	// ****************************************
	// zero wait states: read data is captured in the setup cycle
	always_comb begin
		mapped = isReg(paddr, RSC_OFS_GUARD) | isReg(paddr, RSC_OFS_CAUSE)
			| isReg(paddr, RSC_OFS_LEVEL) | isReg(paddr, RSC_OFS_WDCTL)
			| isReg(paddr, RSC_OFS_STATUS);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prdata_q <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				RSC_OFS_GUARD: prdata_q <= {24'h000000, guard_q};
				RSC_OFS_CAUSE: prdata_q <= {28'h0000000, cause_q};
				RSC_OFS_LEVEL: prdata_q <= {24'h000000, level_q};
				RSC_OFS_WDCTL: prdata_q <= {24'h000000, wdctl_q};
				RSC_OFS_STATUS: prdata_q <= {30'h0, pwrdown_q, timeout_q};
				default: prdata_q <= 32'h00000000;
			endcase
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

endmodule
`default_nettype wire

/* tb/rsc_monitor.sv */
// Concurrent checks on the reset source controller ports.
// Assumes one mclk domain and asynchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
module rsc_monitor import rsc_pkg::*; #(
	parameter int SOFT_RESET_CYC = 4,
	parameter int UV_FILTER_CYC = 6
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic sleepMode,
	input wire logic wdtTimeout,
	input wire logic haltExec,
	input wire logic clrWdt,
	input wire logic fullReset,
	input wire logic pcSpClear,
	input wire logic portInit,
	input wire logic undervoltEnable,
	input wire logic timeoutFlag,
	input wire logic powerdownFlag
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	property p_cause_upper;
		psel && penable && !pwrite && paddr == RSC_OFS_CAUSE |-> prdata[31:4] == 28'h0;
	endproperty
	a_cause_upper: assert property (p_cause_upper) else $error("cause upper bits set");
	property p_uv_sleep;
		undervoltEnable == !sleepMode;
	endproperty
	a_uv_sleep: assert property (p_uv_sleep) else $error("undervolt enable wrong");
	property p_wd_run;
		wdtTimeout && !sleepMode |=> timeoutFlag ##[0:1] fullReset;
	endproperty
	a_wd_run: assert property (p_wd_run) else $error("running timeout wrong");
	property p_wd_sleep;
		wdtTimeout && sleepMode |=> timeoutFlag && powerdownFlag ##[0:1] pcSpClear;
	endproperty
	a_wd_sleep: assert property (p_wd_sleep) else $error("sleep timeout wrong");
	property p_pcsp_only;
		pcSpClear |-> !fullReset;
	endproperty
	a_pcsp_only: assert property (p_pcsp_only) else $error("partial reset not partial");
	property p_halt;
		haltExec && !clrWdt |=> powerdownFlag;
	endproperty
	a_halt: assert property (p_halt) else $error("halt flag missing");
	property p_clr;
		clrWdt && !haltExec && !wdtTimeout |=> !timeoutFlag && !powerdownFlag;
	endproperty
	a_clr: assert property (p_clr) else $error("flags not cleared");
	property p_por_flags;
		$fell(rst) |-> !timeoutFlag && !powerdownFlag;
	endproperty
	a_por_flags: assert property (p_por_flags) else $error("flags after power-on");
	property p_por_ports;
		$fell(rst) |-> portInit && fullReset ##1 !portInit;
	endproperty
	a_por_ports: assert property (p_por_ports) else $error("port init wrong");
endmodule
bind rsc_reset_source_control rsc_monitor #(
	.SOFT_RESET_CYC(SOFT_RESET_CYC),
	.UV_FILTER_CYC(UV_FILTER_CYC)
) mon (
	.mclk(mclk),
	.rst(rst),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.prdata(prdata),
	.sleepMode(sleepMode),
	.wdtTimeout(wdtTimeout),
	.haltExec(haltExec),
	.clrWdt(clrWdt),
	.fullReset(fullReset),
	.pcSpClear(pcSpClear),
	.portInit(portInit),
	.undervoltEnable(undervoltEnable),
	.timeoutFlag(timeoutFlag),
	.powerdownFlag(powerdownFlag)
);
`default_nettype wire

/* tb/tb_reset_source_control.sv */
// Testbench of the reset source controller, APB master tasks.
// Assumes zero-wait APB and shortened delay counts.
`timescale 1ns/1ps
`default_nettype none
module tb_reset_source_control import rsc_pkg::*;;
	logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic lowSupply = 0, sleepMode = 0, wdtTimeout = 0, haltExec = 0, clrWdt = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdata;
	logic pready, pslverr, fullReset, pcSpClear, portInit, undervoltEnable;
	logic wdtEnable, timeoutFlag, powerdownFlag, lastErr, seenFull, seenPc;
	logic [1:0] undervoltLevelSel;
	logic [2:0] wdtPeriodSel;
	logic [7:0] lvl [4] = '{RSC_LEVEL_2V10, RSC_LEVEL_2V55, RSC_LEVEL_3V15, RSC_LEVEL_3V80};
	int fails = 0, totalChecks = 0;
	rsc_reset_source_control #(.SOFT_RESET_CYC(4), .UV_FILTER_CYC(6)) uut (
		.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.lowSupply(lowSupply), .sleepMode(sleepMode), .wdtTimeout(wdtTimeout),
		.haltExec(haltExec), .clrWdt(clrWdt), .fullReset(fullReset), .pcSpClear(pcSpClear),
		.portInit(portInit), .undervoltEnable(undervoltEnable),
		.undervoltLevelSel(undervoltLevelSel), .wdtEnable(wdtEnable),
		.wdtPeriodSel(wdtPeriodSel), .timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag));
	initial forever #2.5 mclk = ~mclk;
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		totalChecks++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		rdata = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		xfer(1'b0, a, 32'h0);
		chk(what, exp, rdata);
	endtask
	// both reset outputs are one-cycle pulses, so poll every cycle
	task waitRst(input int n);
		seenFull = 0;
		seenPc = 0;
		repeat (n) begin
			#1;
			if (fullReset === 1'b1) seenFull = 1;
			if (pcSpClear === 1'b1) seenPc = 1;
			@(posedge mclk);
		end
	endtask
	// one-cycle pulse: 0 watchdog timeout, 1 clear watchdog, 2 halt
	task pulse(input int sel);
		@(posedge mclk);
		case (sel)
			0: wdtTimeout <= 1'b1;
			1: clrWdt <= 1'b1;
			default: haltExec <= 1'b1;
		endcase
		@(posedge mclk);
		wdtTimeout <= 1'b0;
		clrWdt <= 1'b0;
		haltExec <= 1'b0;
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#20000;
		fails++;
		give_verdict();
	end
	initial begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		rd(RSC_OFS_GUARD, 32'h55, "guard");
		rd(RSC_OFS_LEVEL, 32'h55, "level");
		rd(RSC_OFS_WDCTL, 32'h53, "wdctl");
		rd(RSC_OFS_STATUS, 32'h0, "status");
		xfer(1'b1, RSC_OFS_CAUSE, 32'hFF);
		rd(RSC_OFS_CAUSE, 32'h0, "cause");
		rd(8'h14, 32'h0, "unmapped");
		chk("unmapped err", 32'h1, lastErr);
		chk("ready", 32'h1, pready);
		$display("reset values test done");
		xfer(1'b1, RSC_OFS_GUARD, 32'hAA);
		waitRst(20);
		chk("guard valid", 32'h0, seenFull);
		xfer(1'b1, RSC_OFS_GUARD, 32'h12);
		waitRst(20);
		chk("guard invalid", 32'h1, seenFull);
		rd(RSC_OFS_CAUSE, 32'h08, "guard cause");
		rd(RSC_OFS_GUARD, 32'h55, "guard reload");
		xfer(1'b1, RSC_OFS_CAUSE, 32'h0);
		rd(RSC_OFS_CAUSE, 32'h0, "cause clear");
		$display("guard test done");
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, RSC_OFS_LEVEL, {24'h0, lvl[i]});
			#1;
			chk("level sel", i, undervoltLevelSel);
		end
		rd(RSC_OFS_CAUSE, 32'h0, "level codes");
		xfer(1'b1, RSC_OFS_LEVEL, 32'h0);
		waitRst(20);
		chk("level invalid", 32'h1, seenFull);
		rd(RSC_OFS_CAUSE, 32'h02, "level cause");
		rd(RSC_OFS_LEVEL, 32'h55, "level reload");
		xfer(1'b1, RSC_OFS_WDCTL, {24'h0, RSC_WDKEY_DIS, 3'h5});
		#1;
		chk("wd off", 32'h0, wdtEnable);
		chk("wd period", 32'h5, wdtPeriodSel);
		xfer(1'b1, RSC_OFS_WDCTL, 32'h07);
		waitRst(20);
		chk("wd key invalid", 32'h1, seenFull);
		rd(RSC_OFS_CAUSE, 32'h03, "wd cause");
		#1;
		chk("wd on", 32'h1, wdtEnable);
		xfer(1'b1, RSC_OFS_CAUSE, 32'h0);
		$display("config test done");
		xfer(1'b1, RSC_OFS_LEVEL, 32'h33);
		lowSupply <= 1'b1;
		repeat (4) @(posedge mclk);
		lowSupply <= 1'b0;
		waitRst(20);
		chk("short low", 32'h0, seenFull);
		lowSupply <= 1'b1;
		waitRst(30);
		lowSupply <= 1'b0;
		chk("long low", 32'h1, seenFull);
		rd(RSC_OFS_CAUSE, 32'h04, "uv cause");
		rd(RSC_OFS_LEVEL, 32'h33, "level kept");
		sleepMode <= 1'b1;
		lowSupply <= 1'b1;
		waitRst(30);
		chk("sleep low", 32'h0, seenFull);
		chk("uv enable", 32'h0, undervoltEnable);
		lowSupply <= 1'b0;
		sleepMode <= 1'b0;
		xfer(1'b1, RSC_OFS_CAUSE, 32'h0);
		rd(RSC_OFS_CAUSE, 32'h0, "uv clear");
		$display("undervolt test done");
		pulse(0);
		waitRst(10);
		chk("wd run reset", 32'h1, seenFull);
		rd(RSC_OFS_STATUS, 32'h1, "wd run flags");
		chk("timeout pin", 32'h1, timeoutFlag);
		pulse(1);
		sleepMode <= 1'b1;
		pulse(0);
		waitRst(10);
		chk("wd sleep pc", 32'h1, seenPc);
		chk("wd sleep full", 32'h0, seenFull);
		rd(RSC_OFS_STATUS, 32'h3, "wd sleep flags");
		chk("powerdown pin", 32'h1, powerdownFlag);
		sleepMode <= 1'b0;
		pulse(1);
		pulse(2);
		rd(RSC_OFS_STATUS, 32'h2, "halt flags");
		rst <= 1'b1;
		repeat (5) @(posedge mclk);
		chk("port init", 32'h1, portInit);
		chk("por full reset", 32'h1, fullReset);
		rst <= 1'b0;
		rd(RSC_OFS_STATUS, 32'h0, "por flags");
		$display("watchdog test done");
		give_verdict();
	end
endmodule
`default_nettype wire
